//--- rtl/oqsc_pkg.sv
// Shared constants and types for the overlap and queue service control block.
package oqsc_pkg;
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_FEAT = 8'h04;
    localparam logic [7:0] ADDR_SECT_CNT = 8'h08;
    localparam logic [7:0] ADDR_LBA_LO = 8'h0C;
    localparam logic [7:0] ADDR_CYL_LO = 8'h10;
    localparam logic [7:0] ADDR_CYL_HI = 8'h14;
    localparam logic [7:0] ADDR_DEV_HEAD = 8'h18;
    localparam logic [7:0] ADDR_CMD_STAT = 8'h1C;
    localparam logic [7:0] ADDR_DEV_CTL = 8'h20;
    localparam logic [7:0] ADDR_ENGINE = 8'h24;
    localparam logic [7:0] ADDR_CONFIG = 8'h28;
    localparam logic [7:0] ADDR_VALID = 8'h2C;
    localparam logic [7:0] ADDR_READY = 8'h30;
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_SERV = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ERR_ABRT = 2;
    localparam int DC_NIEN = 1;
    localparam int DC_SRST = 2;
    localparam int DH_DEV = 4;
    localparam int FEAT_OVL = 1;
    localparam int ENG_FIN = 0;
    localparam int ENG_REL = 1;
    localparam int ENG_RDY = 2;
    localparam int ENG_ERR = 3;
    localparam int ENG_TAG_LSB = 8;
    localparam int CFG_SUP = 0;
    localparam int CFG_RELEN = 1;
    localparam int TAG_W = 5;
    localparam int QUEUE_DEPTH = 32;
    localparam logic [2:0] PKT_LAST = 3'd5;
    localparam logic [7:0] ID_LAST = 8'hFF;
    localparam logic [7:0] ID_DEPTH_IDX = 8'd75;
    localparam logic [15:0] ID_DEPTH_WORD = 16'(QUEUE_DEPTH - 1);
    localparam logic [1:0] CFG_RESET = 2'b00;
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_DEV_RESET = 8'h08;
    localparam logic [7:0] CMD_PACKET = 8'hA0;
    localparam logic [7:0] CMD_ID_PACKET = 8'hA1;
    localparam logic [7:0] CMD_SERVICE = 8'hA2;
    localparam logic [7:0] CMD_RD_QUEUED = 8'hC7;
    localparam logic [7:0] CMD_WR_QUEUED = 8'hCC;
    localparam logic [7:0] CMD_ID_DEVICE = 8'hEC;
    typedef struct packed {
        logic [7:0] features;
        logic [7:0] sect_cnt;
        logic [7:0] lba_lo;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] dev_head;
    } oqsc_tf_type;
    typedef enum logic [2:0] {
        S_IDLE, S_PKT_PREP, S_PKT_XFER, S_EXEC, S_ID_XFER
    } oqsc_state_type;
endpackage : oqsc_pkg

//--- rtl/oqsc_top.sv
// Device-side command control for packet, overlapped and queued commands.
`timescale 1ns/1ps
`default_nettype none
module oqsc_top #(
    parameter logic [7:0] SIG_SECT_CNT = 8'h01,
    parameter logic [7:0] SIG_LBA_LO = 8'h01,
    parameter logic [7:0] SIG_CYL_LO = 8'hA5,
    parameter logic [7:0] SIG_CYL_HI = 8'h5A,
    parameter logic [15:0] ID_WORD0 = 16'h0001
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dev_strap,
    output logic intrq
);
    oqsc_pkg::oqsc_tf_type tf;
    oqsc_pkg::oqsc_state_type st;
    logic [2:0] pkt_cnt;
    logic [7:0] id_idx;
    logic [4:0] cur_tag;
    logic cur_ovl;
    logic [31:0] valid;
    logic [31:0] ready;
    logic [1:0] cfg;
    logic nien;
    logic err;
    logic pend;
    logic quiet;
    logic strap_s1;
    logic strap_s2;
    logic acc, wr_en, rd_en, bsy, drq, idle_bus, serv, dev_sel, mapped;
    logic [7:0] cmd, status;
    logic [4:0] tag_in, eng_tag, ready_tag;
    logic is_pkt, is_q, is_svc, is_nop, is_idd, is_idp, ovl_cmd;
    logic cmd_wr, soft_rst, c_ok, ev_nonq, ev_dup, ev_poll, ev_idd, ev_svc_none;
    logic abort_imm, ev_accept, ev_svc, eng_wr, eng_fin, eng_rel, eng_err;
    logic data_wr, data_rd, pkt_last, auto_rel, id_last, ev_rel, ev_done;
    logic abort_q, serv_ev, set_norm, set_serv, pend_set, pend_clr;
    logic [31:0] rdata;

    always_comb begin
        acc = psel & penable & pready;
        wr_en = acc & pwrite;
        rd_en = acc & ~pwrite;
        cmd = pwdata[7:0];
        bsy = (st == oqsc_pkg::S_PKT_PREP) | (st == oqsc_pkg::S_EXEC);
        drq = (st == oqsc_pkg::S_PKT_XFER) | (st == oqsc_pkg::S_ID_XFER);
        idle_bus = ~bsy & ~drq;
        serv = |ready;
        dev_sel = tf.dev_head[oqsc_pkg::DH_DEV] == strap_s2;
        tag_in = tf.sect_cnt[oqsc_pkg::TAG_W-1:0];
        eng_tag = pwdata[oqsc_pkg::ENG_TAG_LSB +: oqsc_pkg::TAG_W];
        ready_tag = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (ready[i]) begin
                ready_tag = 5'(i);
            end
        end
        status = 8'h00;
        status[oqsc_pkg::ST_BSY] = bsy;
        status[oqsc_pkg::ST_DRDY] = 1'b1;
        status[oqsc_pkg::ST_SERV] = serv & dev_sel;
        status[oqsc_pkg::ST_DRQ] = drq;
        status[oqsc_pkg::ST_ERR] = err;
        is_pkt = cmd == oqsc_pkg::CMD_PACKET;
        is_q = (cmd == oqsc_pkg::CMD_RD_QUEUED) | (cmd == oqsc_pkg::CMD_WR_QUEUED);
        is_svc = cmd == oqsc_pkg::CMD_SERVICE;
        is_nop = cmd == oqsc_pkg::CMD_NOP;
        is_idd = cmd == oqsc_pkg::CMD_ID_DEVICE;
        is_idp = cmd == oqsc_pkg::CMD_ID_PACKET;
        ovl_cmd = is_q | is_svc | (is_nop & (tf.features != 8'h00))
            | (is_pkt & tf.features[oqsc_pkg::FEAT_OVL] & cfg[oqsc_pkg::CFG_SUP]);
        cmd_wr = wr_en & (paddr == oqsc_pkg::ADDR_CMD_STAT);
        soft_rst = (wr_en & (paddr == oqsc_pkg::ADDR_DEV_CTL) & pwdata[oqsc_pkg::DC_SRST])
            | (cmd_wr & (cmd == oqsc_pkg::CMD_DEV_RESET));
        c_ok = cmd_wr & idle_bus & ~soft_rst;
        ev_nonq = c_ok & ~ovl_cmd & (valid != 32'h0);
        ev_dup = c_ok & is_q & valid[tag_in];
        ev_poll = c_ok & is_nop & (tf.features != 8'h00);
        ev_idd = c_ok & is_idd;
        ev_svc_none = c_ok & is_svc & ~serv;
        abort_imm = ev_nonq | ev_dup | ev_poll | ev_idd | ev_svc_none | (c_ok & is_nop);
        ev_accept = c_ok & ~abort_imm;
        ev_svc = ev_accept & is_svc;
        eng_wr = wr_en & (paddr == oqsc_pkg::ADDR_ENGINE);
        eng_err = eng_wr & pwdata[oqsc_pkg::ENG_ERR] & (st == oqsc_pkg::S_EXEC);
        eng_fin = eng_wr & pwdata[oqsc_pkg::ENG_FIN] & (st == oqsc_pkg::S_EXEC) & ~eng_err;
        eng_rel = eng_wr & pwdata[oqsc_pkg::ENG_REL] & (st == oqsc_pkg::S_EXEC) & ~eng_err
            & ~eng_fin & cur_ovl;
        serv_ev = eng_wr & pwdata[oqsc_pkg::ENG_RDY] & valid[eng_tag];
        data_wr = wr_en & (paddr == oqsc_pkg::ADDR_DATA) & (st == oqsc_pkg::S_PKT_XFER);
        data_rd = rd_en & (paddr == oqsc_pkg::ADDR_DATA) & (st == oqsc_pkg::S_ID_XFER);
        pkt_last = data_wr & (pkt_cnt == oqsc_pkg::PKT_LAST);
        auto_rel = cur_ovl & cfg[oqsc_pkg::CFG_RELEN];
        id_last = data_rd & (id_idx == oqsc_pkg::ID_LAST);
        ev_rel = (pkt_last & auto_rel) | eng_rel;
        ev_done = eng_fin | id_last;
        abort_q = ev_nonq | ev_dup | eng_err;
        set_norm = ev_done | (c_ok & abort_imm) | eng_err;
        set_serv = serv_ev & idle_bus & ~quiet;
        pend_set = set_norm | set_serv;
        pend_clr = (rd_en & (paddr == oqsc_pkg::ADDR_CMD_STAT)) | cmd_wr;
        mapped = (paddr[1:0] == 2'b00) & (paddr <= oqsc_pkg::ADDR_READY);
        rdata = 32'h0;
        unique case (paddr)
            oqsc_pkg::ADDR_DATA: begin
                if (st == oqsc_pkg::S_ID_XFER && id_idx == oqsc_pkg::ID_DEPTH_IDX) begin
                    rdata[15:0] = oqsc_pkg::ID_DEPTH_WORD;
                end else if (st == oqsc_pkg::S_ID_XFER && id_idx == 8'h00) begin
                    rdata[15:0] = ID_WORD0;
                end
            end
            oqsc_pkg::ADDR_FEAT: rdata[oqsc_pkg::ERR_ABRT] = err;
            oqsc_pkg::ADDR_SECT_CNT: rdata[7:0] = tf.sect_cnt;
            oqsc_pkg::ADDR_LBA_LO: rdata[7:0] = tf.lba_lo;
            oqsc_pkg::ADDR_CYL_LO: rdata[7:0] = tf.cyl_lo;
            oqsc_pkg::ADDR_CYL_HI: rdata[7:0] = tf.cyl_hi;
            oqsc_pkg::ADDR_DEV_HEAD: rdata[7:0] = tf.dev_head;
            oqsc_pkg::ADDR_CMD_STAT: rdata[7:0] = status;
            oqsc_pkg::ADDR_DEV_CTL: rdata[7:0] = status;
            oqsc_pkg::ADDR_ENGINE: rdata = {24'h0, 1'b0, cur_ovl, 3'b000, st};
            oqsc_pkg::ADDR_CONFIG: rdata[1:0] = cfg;
            oqsc_pkg::ADDR_VALID: rdata = valid;
            oqsc_pkg::ADDR_READY: rdata = ready;
            default: rdata = 32'h0;
        endcase
    end

    // The slave answers one cycle into the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0 : rdata;
            pslverr <= ~mapped;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
        end else begin
            strap_s1 <= dev_strap;
            strap_s2 <= strap_s1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tf <= '{8'h00, SIG_SECT_CNT, SIG_LBA_LO, SIG_CYL_LO, SIG_CYL_HI, 8'h00};
        end else if (soft_rst || ev_idd) begin
            tf.sect_cnt <= SIG_SECT_CNT;
            tf.lba_lo <= SIG_LBA_LO;
            tf.cyl_lo <= SIG_CYL_LO;
            tf.cyl_hi <= SIG_CYL_HI;
        end else if (ev_svc) begin
            tf.sect_cnt <= {3'b000, ready_tag};
        end else if (wr_en && idle_bus) begin
            unique case (paddr)
                oqsc_pkg::ADDR_FEAT: tf.features <= pwdata[7:0];
                oqsc_pkg::ADDR_SECT_CNT: tf.sect_cnt <= pwdata[7:0];
                oqsc_pkg::ADDR_LBA_LO: tf.lba_lo <= pwdata[7:0];
                oqsc_pkg::ADDR_CYL_LO: tf.cyl_lo <= pwdata[7:0];
                oqsc_pkg::ADDR_CYL_HI: tf.cyl_hi <= pwdata[7:0];
                oqsc_pkg::ADDR_DEV_HEAD: tf.dev_head <= pwdata[7:0];
                default: tf <= tf;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= oqsc_pkg::CFG_RESET;
            nien <= 1'b0;
        end else begin
            if (wr_en && paddr == oqsc_pkg::ADDR_CONFIG) begin
                cfg <= pwdata[1:0];
            end
            if (wr_en && paddr == oqsc_pkg::ADDR_DEV_CTL) begin
                nien <= pwdata[oqsc_pkg::DC_NIEN];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= oqsc_pkg::S_IDLE;
            pkt_cnt <= 3'd0;
            id_idx <= 8'h00;
            cur_tag <= 5'h00;
            cur_ovl <= 1'b0;
        end else if (soft_rst) begin
            st <= oqsc_pkg::S_IDLE;
        end else begin
            unique case (st)
                oqsc_pkg::S_IDLE: begin
                    if (ev_accept) begin
                        cur_ovl <= ovl_cmd;
                        cur_tag <= is_svc ? ready_tag : tag_in;
                        pkt_cnt <= 3'd0;
                        id_idx <= 8'h00;
                        if (is_pkt) begin
                            st <= oqsc_pkg::S_PKT_PREP;
                        end else if (is_idp) begin
                            st <= oqsc_pkg::S_ID_XFER;
                        end else begin
                            st <= oqsc_pkg::S_EXEC;
                        end
                    end
                end
                oqsc_pkg::S_PKT_PREP: st <= oqsc_pkg::S_PKT_XFER;
                oqsc_pkg::S_PKT_XFER: begin
                    if (data_wr) begin
                        pkt_cnt <= pkt_cnt + 3'd1;
                    end
                    if (pkt_last) begin
                        st <= auto_rel ? oqsc_pkg::S_IDLE : oqsc_pkg::S_EXEC;
                    end
                end
                oqsc_pkg::S_EXEC: begin
                    if (eng_fin || eng_rel || eng_err) begin
                        st <= oqsc_pkg::S_IDLE;
                    end
                end
                oqsc_pkg::S_ID_XFER: begin
                    if (data_rd) begin
                        id_idx <= id_idx + 8'h01;
                    end
                    if (id_last) begin
                        st <= oqsc_pkg::S_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid <= 32'h0;
            ready <= 32'h0;
        end else if (soft_rst || abort_q) begin
            valid <= 32'h0;
            ready <= 32'h0;
        end else begin
            if (ev_done && cur_ovl) begin
                valid[cur_tag] <= 1'b0;
            end
            if (ev_svc) begin
                ready[ready_tag] <= 1'b0;
            end
            if (ev_accept && is_q) begin
                valid[tag_in] <= 1'b1;
            end
            if (ev_rel) begin
                valid[cur_tag] <= 1'b1;
            end
            if (serv_ev) begin
                ready[eng_tag] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err <= 1'b0;
        end else if (c_ok && abort_imm || eng_err) begin
            err <= 1'b1;
        end else if (ev_accept || soft_rst) begin
            err <= 1'b0;
        end
    end

    // Quiet blocks further service interrupts until SERV drops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet <= 1'b0;
            pend <= 1'b0;
            intrq <= 1'b0;
        end else begin
            if (serv_ev || (c_ok && serv)) begin
                quiet <= 1'b1;
            end else if (!serv || soft_rst) begin
                quiet <= 1'b0;
            end
            if (pend_set) begin
                pend <= 1'b1;
            end else if (pend_clr || soft_rst) begin
                pend <= 1'b0;
            end
            intrq <= pend & ~nien & dev_sel;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_pkt_issue;
        ev_accept && is_pkt;
    endsequence
    sequence s_pkt_ready;
        bsy && !drq ##1 drq && !bsy;
    endsequence
    property p_pkt_handshake;
        s_pkt_issue |=> s_pkt_ready;
    endproperty
    a_pkt_handshake: assert property (p_pkt_handshake) else $error("packet handshake wrong");
    property p_pkt_last;
        pkt_last && !auto_rel && !soft_rst |=> bsy && !drq;
    endproperty
    a_pkt_last: assert property (p_pkt_last) else $error("no busy after packet");
    property p_sig;
        soft_rst |=> tf.sect_cnt == SIG_SECT_CNT && tf.cyl_hi == SIG_CYL_HI && idle_bus;
    endproperty
    a_sig: assert property (p_sig) else $error("signature missing");
    property p_idd;
        ev_idd |=> err && idle_bus && tf.cyl_lo == SIG_CYL_LO;
    endproperty
    a_idd: assert property (p_idd) else $error("identify not aborted");
    property p_release;
        ev_rel && !soft_rst |=> !bsy && !drq && valid[$past(cur_tag)];
    endproperty
    a_release: assert property (p_release) else $error("release wrong");
    property p_nonovl;
        st == oqsc_pkg::S_EXEC && !cur_ovl && eng_wr && pwdata[oqsc_pkg::ENG_REL]
            && !pwdata[oqsc_pkg::ENG_FIN] && !pwdata[oqsc_pkg::ENG_ERR] |=> bsy;
    endproperty
    a_nonovl: assert property (p_nonovl) else $error("released non-overlap command");
    property p_intrq_sel;
        intrq |-> $past(pend) && $past(dev_sel) && !$past(nien);
    endproperty
    a_intrq_sel: assert property (p_intrq_sel) else $error("intrq ungated");
    property p_poll;
        ev_poll |=> err && valid == $past(valid) && idle_bus;
    endproperty
    a_poll: assert property (p_poll) else $error("poll disturbed queue");
    property p_nonq;
        ev_nonq |=> valid == 32'h0 && err;
    endproperty
    a_nonq: assert property (p_nonq) else $error("queue kept");
    property p_word75;
        psel && penable && !pready && !pwrite && paddr == oqsc_pkg::ADDR_DATA
            && st == oqsc_pkg::S_ID_XFER && id_idx == oqsc_pkg::ID_DEPTH_IDX
            |=> prdata[15:0] == oqsc_pkg::ID_DEPTH_WORD;
    endproperty
    a_word75: assert property (p_word75) else $error("depth word wrong");
    property p_svc_tag;
        ev_svc |=> tf.sect_cnt == {3'b000, $past(ready_tag)};
    endproperty
    a_svc_tag: assert property (p_svc_tag) else $error("tag not restored");
    property p_dup;
        ev_dup |=> valid == 32'h0 && err;
    endproperty
    a_dup: assert property (p_dup) else $error("duplicate tag kept queue");
    property p_serv_int;
        set_serv |=> pend ##1 ((intrq == ($past(dev_sel) && !$past(nien))) || $past(pend_clr));
    endproperty
    a_serv_int: assert property (p_serv_int) else $error("service interrupt missing");
    property p_pend_clr;
        pend_clr && !pend_set |=> !pend;
    endproperty
    a_pend_clr: assert property (p_pend_clr) else $error("pending not cleared");
    property p_quiet;
        serv_ev && !idle_bus && !pend && !set_norm |=> !pend && serv;
    endproperty
    a_quiet: assert property (p_quiet) else $error("extra service interrupt");
endmodule : oqsc_top
`default_nettype wire

//--- dv/oqsc_host.sv
// Host adapter model that issues APB transfers to the device.
`timescale 1ns/1ps
`default_nettype none
module oqsc_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Holds the request until pready is sampled high, then releases it.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : oqsc_host
`default_nettype wire

//--- dv/testbench.sv
// Self-checking testbench for the overlap and queue service control block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] DATA = oqsc_pkg::ADDR_DATA;
    localparam logic [7:0] FEAT = oqsc_pkg::ADDR_FEAT;
    localparam logic [7:0] SECT = oqsc_pkg::ADDR_SECT_CNT;
    localparam logic [7:0] CMD = oqsc_pkg::ADDR_CMD_STAT;
    localparam logic [7:0] DCTL = oqsc_pkg::ADDR_DEV_CTL;
    localparam logic [7:0] ENG = oqsc_pkg::ADDR_ENGINE;
    localparam logic [7:0] VAL = oqsc_pkg::ADDR_VALID;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic dev_strap = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, intrq, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    int err_count = 0;
    int checks = 0;
    always #50 pclk = ~pclk;
    oqsc_top oqsc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dev_strap(dev_strap), .intrq(intrq));
    oqsc_host oqsc_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        oqsc_host_inst.xfer(1'b1, a, d, q, last_err);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        oqsc_host_inst.xfer(1'b0, a, 32'h0, r, last_err);
        chk(nm, exp, r);
    endtask : rd
    task automatic pkt_run();
        wr(CMD, 32'(oqsc_pkg::CMD_PACKET));
        rd(CMD, 32'h48, "packet drq");
        for (int i = 0; i < 6; i++) begin
            wr(DATA, 32'h1234);
        end
    endtask : pkt_run
    task automatic qcmd(input logic [7:0] op, input logic [31:0] tag);
        wr(SECT, tag);
        wr(DCTL, 32'h2);
        wr(CMD, 32'(op));
        wr(DCTL, 32'h0);
    endtask : qcmd
    task automatic see_intrq(input logic exp, input string nm);
        repeat (3) @(posedge pclk);
        chk(nm, {31'h0, exp}, {31'h0, intrq});
    endtask : see_intrq
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(SECT, 32'h01, "sig sect");
        rd(oqsc_pkg::ADDR_CYL_LO, 32'hA5, "sig cyl lo");
        rd(oqsc_pkg::ADDR_CYL_HI, 32'h5A, "sig cyl hi");
        rd(CMD, 32'h40, "status idle");
        rd(8'h34, 32'h0, "unmapped read");
        chk("unmapped slverr", 32'h1, {31'h0, last_err});
        pkt_run();
        wr(ENG, 32'h2);
        rd(CMD, 32'hC0, "packet busy");
        wr(ENG, 32'h1);
        see_intrq(1'b1, "intrq done");
        rd(CMD, 32'h40, "status done");
        see_intrq(1'b0, "intrq cleared");
        wr(oqsc_pkg::ADDR_LBA_LO, 32'h77);
        wr(CMD, 32'(oqsc_pkg::CMD_ID_DEVICE));
        rd(CMD, 32'h41, "id device status");
        rd(FEAT, 32'h04, "id device abort");
        rd(oqsc_pkg::ADDR_LBA_LO, 32'h01, "id device sig");
        wr(CMD, 32'(oqsc_pkg::CMD_ID_PACKET));
        for (int i = 0; i < 256; i++) begin
            oqsc_host_inst.xfer(1'b0, DATA, 32'h0, r, last_err);
            if (i == 0) begin
                chk("identify word0", 32'h1, r);
            end
            if (i == 75) begin
                chk("queue depth word", 32'h1F, r);
            end
        end
        rd(CMD, 32'h40, "id packet end");
        wr(oqsc_pkg::ADDR_CONFIG, 32'h3);
        wr(FEAT, 32'h2);
        wr(SECT, 32'h5);
        pkt_run();
        rd(CMD, 32'h40, "released");
        rd(VAL, 32'h20, "valid tag5");
        see_intrq(1'b0, "no release intrq");
        wr(ENG, 32'h504);
        see_intrq(1'b1, "service intrq");
        wr(DCTL, 32'h2);
        see_intrq(1'b0, "intrq masked");
        dev_strap <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(DCTL, 32'h40, "unselected serv");
        dev_strap <= 1'b0;
        repeat (4) @(posedge pclk);
        wr(DCTL, 32'h0);
        rd(CMD, 32'h50, "serv set");
        wr(SECT, 32'h1F);
        wr(CMD, 32'(oqsc_pkg::CMD_SERVICE));
        rd(SECT, 32'h05, "service tag");
        wr(ENG, 32'h1);
        rd(oqsc_pkg::ADDR_READY, 32'h0, "ready empty");
        rd(CMD, 32'h40, "serv clear");
        qcmd(oqsc_pkg::CMD_RD_QUEUED, 32'h3);
        wr(ENG, 32'h2);
        rd(VAL, 32'h08, "queued tag3");
        qcmd(oqsc_pkg::CMD_WR_QUEUED, 32'h3);
        rd(CMD, 32'h41, "dup tag status");
        rd(VAL, 32'h0, "dup tag queue");
        qcmd(oqsc_pkg::CMD_RD_QUEUED, 32'h2);
        wr(ENG, 32'h2);
        wr(FEAT, 32'h1);
        wr(CMD, 32'(oqsc_pkg::CMD_NOP));
        rd(CMD, 32'h41, "auto poll status");
        rd(VAL, 32'h04, "auto poll queue");
        wr(CMD, 32'hE7);
        rd(CMD, 32'h41, "non queued status");
        rd(VAL, 32'h0, "non queued queue");
        qcmd(oqsc_pkg::CMD_RD_QUEUED, 32'h4);
        wr(ENG, 32'h404);
        see_intrq(1'b0, "busy ready no intrq");
        rd(DCTL, 32'hD0, "busy serv");
        wr(ENG, 32'h8);
        rd(CMD, 32'h41, "error status");
        rd(VAL, 32'h0, "error queue");
        wr(DCTL, 32'h4);
        wr(DCTL, 32'h0);
        rd(SECT, 32'h01, "soft reset sig");
        rd(CMD, 32'h40, "soft reset status");
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
